// *** hw/bnr_err_flags.sv ***
module bnr_err_flags
   import bnr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Events and software clear
   input wire logic [HALF_W-1:0] hardErrEvent,
   input wire logic [HALF_W-1:0] softErrEvent,
   input wire logic clrEn,
   input wire logic [DATA_W-1:0] clrMask,
   // Flags and summaries
   output logic [DATA_W-1:0] errFlags,
   output logic hardSummary,
   output logic softSummary
);
   logic [DATA_W-1:0] setVec;
   logic [DATA_W-1:0] flags_r;

   assign setVec = {hardErrEvent, softErrEvent};

   // Set wins over a clear in the same cycle
   genvar i;
   for (i = 0; i < DATA_W; i++) begin : g_flag
      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) begin
            flags_r[i] <= 1'b0;
         end else if (setVec[i]) begin
            flags_r[i] <= 1'b1;
         end else if (clrEn && clrMask[i]) begin
            flags_r[i] <= 1'b0;
         end
      end
   end

   assign errFlags = flags_r;
   assign hardSummary = |flags_r[ERR_HARD_LSB +: HALF_W];
   assign softSummary = |flags_r[ERR_SOFT_LSB +: HALF_W];

   property p_set_wins;
      @(posedge ref_clk) disable iff (!arst_n)
      (setVec != '0) |=> ((flags_r & $past(setVec)) == $past(setVec));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("error flag event lost");
endmodule : bnr_err_flags

// *** hw/bnr_node_regs.sv ***
module bnr_node_regs
   import bnr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Node register access
   input wire logic regReq,
   input wire logic regWrite,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWdata,
   output logic regAck,
   output logic regNoAck,
   output logic [DATA_W-1:0] regRdata,
   // Self-test pins from the interface chip and port
   input wire logic chipDonePin,
   input wire logic chipPassPin,
   input wire logic portDonePin,
   input wire logic portPassPin,
   // Error events from bus logic
   input wire logic [HALF_W-1:0] hardErrEvent,
   input wire logic [HALF_W-1:0] softErrEvent,
   // Port status from adapter logic
   input wire logic [DATA_W-1:0] failAddrIn,
   input wire logic [DATA_W-1:0] portParamIn,
   // Node status
   output logic busDriverEn,
   output logic selftestFailed
);
   // Returns the plain storage index, or NUM_PLAIN when none matches
   function automatic logic [IDX_W-1:0] plainIndex(
      input logic [ADDR_W-1:0] addr
   );
      logic [IDX_W-1:0] idx;
      idx = IDX_W'(NUM_PLAIN);
      for (int k = 0; k < NUM_PLAIN; k++) begin
         if (addr == PLAIN_OFF[k]) begin
            idx = IDX_W'(k);
         end
      end
      return idx;
   endfunction : plainIndex

   logic [DATA_W-1:0] idReg_r;
   logic [DATA_W-1:0] plain_r [NUM_PLAIN];
   logic [DATA_W-1:0] errFlags;
   logic [DATA_W-1:0] csrView;
   logic [DATA_W-1:0] rdata_nxt;
   logic [DATA_W-1:0] rdata_r;
   logic [IDX_W-1:0] reqIdx;
   logic hardSummary;
   logic softSummary;
   logic brokeFlag;
   logic stsFlag;
   logic chipPassed;
   logic wrEn;
   logic rdEn;
   logic wrId;
   logic wrCsr;
   logic wrErr;
   logic stsRefused;
   logic ack_r;
   logic no_acknowledge_response_r;
   logic idWritten_r;

   assign wrEn = regReq && regWrite;
   assign rdEn = regReq && !regWrite;
   assign reqIdx = plainIndex(regAddr);
   assign wrId = wrEn && regAddr == OFF_NODE_TYPE;
   assign wrCsr = wrEn && regAddr == OFF_CTRL_STATUS;
   assign wrErr = wrEn && regAddr == OFF_BUS_ERR;
   // Driver is off, so the node cannot answer this write itself
   assign stsRefused = wrCsr && regWdata[CS_STS_BIT] && !stsFlag;

   bnr_err_flags u_err (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .hardErrEvent(hardErrEvent),
      .softErrEvent(softErrEvent),
      .clrEn(wrErr),
      .clrMask(regWdata),
      .errFlags(errFlags),
      .hardSummary(hardSummary),
      .softSummary(softSummary)
   );

   // The write still lands so a loopback write can enable drivers
   bnr_selftest u_test (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .testPins({portPassPin, portDonePin, chipPassPin, chipDonePin}),
      .wrClearFail(wrCsr && regWdata[CS_SELFTEST_FAILURE_FLAG_BIT]),
      .wrStsSet(wrCsr && regWdata[CS_STS_BIT]),
      .wrStsClr(wrCsr && !regWdata[CS_STS_BIT]),
      .brokeFlag(brokeFlag),
      .stsFlag(stsFlag),
      .chipPassed(chipPassed)
   );

   // Identification register; the reserved bit is never stored
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         idReg_r <= ID_RESET;
      end else if (wrId) begin
         idReg_r <= regWdata;
         idReg_r[ID_RSVD_BIT] <= 1'b0;
      end
   end

   // Tracks whether software has overwritten the identity values
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         idWritten_r <= 1'b0;
      end else if (wrId) begin
         idWritten_r <= 1'b1;
      end
   end

   genvar g;
   for (g = 0; g < NUM_PLAIN; g++) begin : g_plain
      always_ff @(posedge ref_clk or negedge arst_n) begin
         if (!arst_n) begin
            plain_r[g] <= PLAIN_RESET;
         end else if (wrEn && reqIdx == IDX_W'(g)) begin
            plain_r[g] <= regWdata;
         end
      end
   end

   // Unused bit 13 and bits outside this block read as zero
   always_comb begin
      csrView = '0;
      csrView[CS_REV_LSB +: 8] = IFACE_REV;
      csrView[CS_TYPE_LSB +: 8] = IFACE_TYPE;
      csrView[CS_HES_BIT] = hardSummary;
      csrView[CS_SES_BIT] = softSummary;
      csrView[CS_UNUSED_BIT] = 1'b0;
      csrView[CS_SELFTEST_FAILURE_FLAG_BIT] = brokeFlag;
      csrView[CS_STS_BIT] = stsFlag;
   end

   always_comb begin
      rdata_nxt = '0;
      if (regAddr == OFF_NODE_TYPE) begin
         rdata_nxt = idReg_r;
      end else if (regAddr == OFF_CTRL_STATUS) begin
         rdata_nxt = csrView;
      end else if (regAddr == OFF_BUS_ERR) begin
         rdata_nxt = errFlags;
      end else if (regAddr == OFF_FAIL_ADDR) begin
         rdata_nxt = failAddrIn;
      end else if (regAddr == OFF_PORT_PARAM) begin
         rdata_nxt = portParamIn;
      end else if (reqIdx != IDX_W'(NUM_PLAIN)) begin
         rdata_nxt = plain_r[reqIdx];
      end else begin
         rdata_nxt = '0;
      end
   end

   // Read data stays until the next read is taken
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= '0;
      end else if (rdEn) begin
         rdata_r <= rdata_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         ack_r <= 1'b0;
         no_acknowledge_response_r <= 1'b0;
      end else begin
         ack_r <= regReq && !stsRefused;
         no_acknowledge_response_r <= stsRefused;
      end
   end

   assign regAck = ack_r;
   assign regNoAck = no_acknowledge_response_r;
   assign regRdata = rdata_r;
   assign busDriverEn = stsFlag;
   assign selftestFailed = brokeFlag;

   property p_id_type;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && regAddr == OFF_NODE_TYPE)
         |=> regAck && regRdata[15:0] == $past(idReg_r[15:0]);
   endproperty
   a_id_type: assert property (p_id_type)
      else $error("node type code read back wrong");

   property p_id_revs;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && regAddr == OFF_NODE_TYPE)
         |=> regRdata[28:16] == $past(idReg_r[28:16]);
   endproperty
   a_id_revs: assert property (p_id_revs)
      else $error("revision fields read back wrong");

   property p_id_rsvd;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && regAddr == OFF_NODE_TYPE)
         |=> !regRdata[ID_RSVD_BIT]
         && regRdata[31:30] == $past(idReg_r[31:30]);
   endproperty
   a_id_rsvd: assert property (p_id_rsvd)
      else $error("buffer, duplex or reserved bit wrong");

   property p_csr_const;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && regAddr == OFF_CTRL_STATUS)
         |=> regRdata[31:24] == IFACE_REV
         && regRdata[23:16] == IFACE_TYPE;
   endproperty
   a_csr_const: assert property (p_csr_const)
      else $error("interface revision or type wrong");

   property p_hes;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && regAddr == OFF_CTRL_STATUS)
         |=> regRdata[CS_HES_BIT] == (|$past(errFlags[31:16]));
   endproperty
   a_hes: assert property (p_hes)
      else $error("hard error summary mismatch");

   property p_ses;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && regAddr == OFF_CTRL_STATUS)
         |=> regRdata[CS_SES_BIT] == (|$past(errFlags[15:0]));
   endproperty
   a_ses: assert property (p_ses)
      else $error("soft error summary mismatch");

   property p_unused;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && regAddr == OFF_CTRL_STATUS) |=> !regRdata[CS_UNUSED_BIT];
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused bit read as one");

   property p_w1c;
      @(posedge ref_clk) disable iff (!arst_n)
      (wrCsr && regWdata[CS_SELFTEST_FAILURE_FLAG_BIT]) |=> !brokeFlag;
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("failure flag not cleared by write of one");

   property p_drv_en;
      @(posedge ref_clk) disable iff (!arst_n)
      busDriverEn == stsFlag && (!busDriverEn || chipPassed);
   endproperty
   a_drv_en: assert property (p_drv_en)
      else $error("driver enable does not follow pass flag");

   property p_no_acknowledge_response;
      @(posedge ref_clk) disable iff (!arst_n)
      (wrCsr && regWdata[CS_STS_BIT] && !stsFlag)
         |=> regNoAck && !regAck ##1 !regNoAck;
   endproperty
   a_no_acknowledge_response: assert property (p_no_acknowledge_response)
      else $error("no-acknowledge missing for pass flag write");

   property p_rsvd_read;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && (regAddr == OFF_RSVD_A || regAddr == OFF_RSVD_B
         || regAddr == OFF_RSVD_C)) |=> regAck && regRdata == '0;
   endproperty
   a_rsvd_read: assert property (p_rsvd_read)
      else $error("reserved offset read not zero");

   property p_rsvd_write;
      @(posedge ref_clk) disable iff (!arst_n)
      (wrEn && reqIdx == IDX_W'(NUM_PLAIN) && regAddr == OFF_RSVD_A)
         |=> $stable(idReg_r) && $stable(stsFlag);
   endproperty
   a_rsvd_write: assert property (p_rsvd_write)
      else $error("reserved write had a side effect");

   property p_id_fixed;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && regAddr == OFF_NODE_TYPE && !idWritten_r)
         |=> regRdata[ID_TYPE_LSB +: HALF_W] == NODE_TYPE_CODE
         && regRdata[ID_PREV_LSB +: $bits(PORT_REV)] == PORT_REV
         && regRdata[ID_LREV_LSB +: $bits(LINK_REV)] == LINK_REV;
   endproperty
   a_id_fixed: assert property (p_id_fixed)
      else $error("identity fields differ from their fixed values");

   property p_id_write;
      @(posedge ref_clk) disable iff (!arst_n)
      wrId |=> !idReg_r[ID_RSVD_BIT]
         && idReg_r[ID_BUF_BIT] == $past(regWdata[ID_BUF_BIT])
         && idReg_r[ID_DUPLEX_BIT] == $past(regWdata[ID_DUPLEX_BIT]);
   endproperty
   a_id_write: assert property (p_id_write)
      else $error("identification write stored wrongly");

   property p_read_ack;
      @(posedge ref_clk) disable iff (!arst_n)
      rdEn |=> regAck && !regNoAck;
   endproperty
   a_read_ack: assert property (p_read_ack)
      else $error("read not acknowledged");

   property p_write_ack;
      @(posedge ref_clk) disable iff (!arst_n)
      (wrEn && !stsRefused) |=> regAck && !regNoAck;
   endproperty
   a_write_ack: assert property (p_write_ack)
      else $error("accepted write not acknowledged");

   property p_csr_flags;
      @(posedge ref_clk) disable iff (!arst_n)
      (rdEn && regAddr == OFF_CTRL_STATUS)
         |=> regRdata[CS_SELFTEST_FAILURE_FLAG_BIT] == $past(brokeFlag)
         && regRdata[CS_STS_BIT] == $past(stsFlag);
   endproperty
   a_csr_flags: assert property (p_csr_flags)
      else $error("self-test flags read back wrong");

   property p_err_clear;
      @(posedge ref_clk) disable iff (!arst_n)
      wrErr |=> (errFlags & $past(regWdata)
         & ~$past({hardErrEvent, softErrEvent})) == '0;
   endproperty
   a_err_clear: assert property (p_err_clear)
      else $error("error flag survived a write of one");
endmodule : bnr_node_regs

// *** hw/bnr_pkg.sv ***
package bnr_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int HALF_W = 16;

   // Node space offsets
   localparam logic [7:0] OFF_NODE_TYPE = 8'h00;
   localparam logic [7:0] OFF_CTRL_STATUS = 8'h04;
   localparam logic [7:0] OFF_BUS_ERR = 8'h08;
   localparam logic [7:0] OFF_ERR_IRQ = 8'h0c;
   localparam logic [7:0] OFF_IRQ_DEST = 8'h10;
   localparam logic [7:0] OFF_IP_MASK = 8'h14;
   localparam logic [7:0] OFF_FORCE_DEST = 8'h18;
   localparam logic [7:0] OFF_IP_SOURCE = 8'h1c;
   localparam logic [7:0] OFF_RSVD_A = 8'h20;
   localparam logic [7:0] OFF_RSVD_B = 8'h24;
   localparam logic [7:0] OFF_USER_CS = 8'h28;
   localparam logic [7:0] OFF_WRITE_STATUS = 8'h2c;
   localparam logic [7:0] OFF_RSVD_C = 8'h30;
   localparam logic [7:0] OFF_USER_IRQ = 8'h40;
   localparam logic [7:0] OFF_QUEUE_BASE = 8'hf0;
   localparam logic [7:0] OFF_FAIL_ADDR = 8'hf4;
   localparam logic [7:0] OFF_PORT_PARAM = 8'hf8;
   localparam logic [7:0] OFF_PORT_ERR = 8'hfc;

   // Plain storage registers, held in one indexed array
   localparam int NUM_PLAIN = 10;
   localparam int IDX_W = 4;
   localparam logic [7:0] PLAIN_OFF [NUM_PLAIN] = '{
      OFF_ERR_IRQ, OFF_IRQ_DEST, OFF_IP_MASK, OFF_FORCE_DEST,
      OFF_IP_SOURCE, OFF_USER_CS, OFF_WRITE_STATUS, OFF_USER_IRQ,
      OFF_QUEUE_BASE, OFF_PORT_ERR};
   localparam logic [31:0] PLAIN_RESET = 32'h0000_0000;

   // Node identification fields
   localparam int ID_TYPE_LSB = 0;
   localparam int ID_PREV_LSB = 16;
   localparam int ID_LREV_LSB = 24;
   localparam int ID_RSVD_BIT = 29;
   localparam int ID_BUF_BIT = 30;
   localparam int ID_DUPLEX_BIT = 31;
   // Arbitrary identity values
   localparam logic [15:0] NODE_TYPE_CODE = 16'h5a5a;
   localparam logic [7:0] PORT_REV = 8'h01;
   localparam logic [4:0] LINK_REV = 5'h01;
   localparam logic BUF_IS_4K = 1'b0;
   localparam logic FULL_DUPLEX = 1'b0;
   localparam logic [31:0] ID_RESET = {FULL_DUPLEX, BUF_IS_4K, 1'b0,
      LINK_REV, PORT_REV, NODE_TYPE_CODE};

   // Control and status fields
   localparam int CS_REV_LSB = 24;
   localparam int CS_TYPE_LSB = 16;
   localparam int CS_HES_BIT = 15;
   localparam int CS_SES_BIT = 14;
   localparam int CS_UNUSED_BIT = 13;
   localparam int CS_SELFTEST_FAILURE_FLAG_BIT = 12;
   localparam int CS_STS_BIT = 11;
   // Arbitrary identity values
   localparam logic [7:0] IFACE_REV = 8'h02;
   localparam logic [7:0] IFACE_TYPE = 8'h3c;

   // Bus error flags: soft in the low half, hard in the high half
   localparam int ERR_SOFT_LSB = 0;
   localparam int ERR_HARD_LSB = 16;

   localparam int NUM_PINS = 4;
   typedef enum logic [1:0] {PORT_RUN, PORT_PASS, PORT_FAIL} bnr_port_type;
endpackage : bnr_pkg

// *** hw/bnr_selftest.sv ***
module bnr_selftest
   import bnr_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Self-test pins: chip done, chip pass, port done, port pass
   input wire logic [NUM_PINS-1:0] testPins,
   // Software requests
   input wire logic wrClearFail,
   input wire logic wrStsSet,
   input wire logic wrStsClr,
   // Status
   output logic brokeFlag,
   output logic stsFlag,
   output logic chipPassed
);
   logic [NUM_PINS-1:0] sync1_r;
   logic [NUM_PINS-1:0] sync2_r;
   logic chipPassed_r;
   logic selftest_failure_flag_r;
   logic sts_r;
   logic chipPassEvt;
   bnr_port_type portState_r;

   // Two stages before any logic looks at the pins
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= testPins;
         sync2_r <= sync1_r;
      end
   end

   assign chipPassEvt = sync2_r[0] && sync2_r[1] && !chipPassed_r;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         chipPassed_r <= 1'b0;
      end else if (chipPassEvt) begin
         chipPassed_r <= 1'b1;
      end
   end

   // First completion after power-up is final; later pulses are ignored
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         portState_r <= PORT_RUN;
      end else begin
         case (portState_r)
            PORT_RUN: begin
               if (sync2_r[2]) begin
                  portState_r <= sync2_r[3] ? PORT_PASS : PORT_FAIL;
               end
            end
            default: begin
               portState_r <= portState_r;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         selftest_failure_flag_r <= 1'b1;
      end else if (chipPassed_r && portState_r == PORT_PASS) begin
         selftest_failure_flag_r <= 1'b0;
      end else if (wrClearFail) begin
         selftest_failure_flag_r <= 1'b0;
      end
   end

   // A failed chip never gets its drivers turned on
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sts_r <= 1'b0;
      end else if (chipPassEvt) begin
         sts_r <= 1'b1;
      end else if (wrStsSet && chipPassed_r) begin
         sts_r <= 1'b1;
      end else if (wrStsClr) begin
         sts_r <= 1'b0;
      end
   end

   assign brokeFlag = selftest_failure_flag_r;
   assign stsFlag = sts_r;
   assign chipPassed = chipPassed_r;

   property p_no_drive_failed;
      @(posedge ref_clk) disable iff (!arst_n)
      !chipPassed_r |-> !sts_r;
   endproperty
   a_no_drive_failed: assert property (p_no_drive_failed)
      else $error("drivers enabled without chip self-test pass");

   property p_port_once;
      @(posedge ref_clk) disable iff (!arst_n)
      (portState_r != PORT_RUN) |=> $stable(portState_r);
   endproperty
   a_port_once: assert property (p_port_once)
      else $error("port self-test result changed after power-up");

   property p_selftest_failure_flag_clear;
      @(posedge ref_clk) disable iff (!arst_n)
      (chipPassed_r && portState_r == PORT_PASS) |=> !selftest_failure_flag_r;
   endproperty
   a_selftest_failure_flag_clear: assert property (p_selftest_failure_flag_clear)
      else $error("failure flag not cleared after both self-tests");

   property p_sts_on_pass;
      @(posedge ref_clk) disable iff (!arst_n)
      chipPassEvt |=> sts_r [*2];
   endproperty
   a_sts_on_pass: assert property (p_sts_on_pass)
      else $error("pass flag not set after chip self-test");
endmodule : bnr_selftest

// *** verif/backplane_node_required_regs_test.sv ***
`define CHK(got, exp) begin checksDone++; if ((got) !== (exp)) begin \
   errors++; $display("ERROR %0t: got %h want %h", $time, got, exp); \
   end end

module backplane_node_required_regs_test
   import bnr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic ref_clk, arst_n, regReq, regWrite, regAck, regNoAck;
   logic chipDonePin, chipPassPin, portDonePin, portPassPin;
   logic busDriverEn, selftestFailed;
   logic [HALF_W-1:0] hardErrEvent, softErrEvent;
   logic [DATA_W-1:0] failAddrIn, portParamIn, regWdata, regRdata, r;
   logic [ADDR_W-1:0] regAddr;
   logic [7:0] rsvd [8] = '{8'h20, 8'h24, 8'h30, 8'h34, 8'h06, 8'hf4,
      8'hf8, 8'h44};
   int errors, checksDone;
   logic [31:0] lfsrState = 32'hf28f83ea;
   // Bench model of the register set
   logic [31:0] mIdr, mErr;
   logic mPass, mFail, mChip;
   logic [31:0] mPlain [logic [7:0]];

   bnr_node_regs uut (.ref_clk(ref_clk), .arst_n(arst_n),
      .regReq(regReq), .regWrite(regWrite), .regAddr(regAddr),
      .regWdata(regWdata), .regAck(regAck), .regNoAck(regNoAck),
      .regRdata(regRdata), .chipDonePin(chipDonePin),
      .chipPassPin(chipPassPin), .portDonePin(portDonePin),
      .portPassPin(portPassPin), .hardErrEvent(hardErrEvent),
      .softErrEvent(softErrEvent), .failAddrIn(failAddrIn),
      .portParamIn(portParamIn), .busDriverEn(busDriverEn),
      .selftestFailed(selftestFailed));

   bnr_host_model host (.ref_clk(ref_clk), .regReq(regReq),
      .regWrite(regWrite), .regAddr(regAddr), .regWdata(regWdata),
      .regAck(regAck), .regNoAck(regNoAck), .regRdata(regRdata));

   initial begin
      ref_clk = 1'h0;
      forever #20 ref_clk = ~ref_clk;
   end

   function automatic logic [31:0] rnd();
      lfsrState = {lfsrState[30:0], lfsrState[31] ^ lfsrState[21] ^
         lfsrState[1] ^ lfsrState[0]};
      return lfsrState;
   endfunction : rnd

   function automatic logic [31:0] expRead(input logic [7:0] a);
      case (a)
         OFF_NODE_TYPE: return mIdr;
         OFF_CTRL_STATUS: return {IFACE_REV, IFACE_TYPE, |mErr[31:16],
            |mErr[15:0], 1'h0, mFail, mPass, 11'h000};
         OFF_BUS_ERR: return mErr;
         OFF_FAIL_ADDR: return failAddrIn;
         OFF_PORT_PARAM: return portParamIn;
         default: return mPlain.exists(a) ? mPlain[a] : 32'h0;
      endcase
   endfunction : expRead

   task automatic stop_test();
      $display("Checks %0d, errors %0d", checksDone, errors);
      if (errors == 0 && checksDone > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic acc(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      logic [31:0] rd, expv;
      logic ak, nk, to, expNk;
      int gap;
      expv = expRead(a);
      expNk = wr && a == OFF_CTRL_STATUS && d[CS_STS_BIT] && !mPass;
      gap = int'(rnd() & 32'h3);
      host.access(wr, a, d, gap, rd, ak, nk, to);
      if (to) begin
         errors++;
         $display("ERROR %0t: no answer at %h", $time, a);
         stop_test();
      end
      `CHK(nk, expNk)
      `CHK(ak, !expNk)
      if (!wr) `CHK(rd, expv)
      if (wr) begin
         case (a)
            OFF_NODE_TYPE: mIdr = d & ~32'h2000_0000;
            OFF_CTRL_STATUS: begin
               if (d[CS_SELFTEST_FAILURE_FLAG_BIT]) mFail = 1'h0;
               mPass = d[CS_STS_BIT] ? (mPass | mChip) : 1'h0;
            end
            OFF_BUS_ERR: mErr = mErr & ~d;
            default: if (mPlain.exists(a)) mPlain[a] = d;
         endcase
      end
   endtask : acc

   task automatic doReset();
      arst_n = 1'h0;
      repeat (10) @(posedge ref_clk);
      #1;
      `CHK(busDriverEn, 1'h0)
      `CHK(selftestFailed, 1'h1)
      arst_n = 1'h1;
      mIdr = ID_RESET;
      mErr = 32'h0;
      mPass = 1'h0;
      mFail = 1'h1;
      mChip = 1'h0;
      for (int i = 0; i < NUM_PLAIN; i++) mPlain[PLAIN_OFF[i]] = PLAIN_RESET;
   endtask : doReset

   task automatic pins(input logic [3:0] v);
      @(posedge ref_clk);
      #1;
      {chipDonePin, chipPassPin, portDonePin, portPassPin} = v;
   endtask : pins

   // Bounded wait for a level, then compare
   task automatic waitSig(ref logic s, input logic v);
      int n;
      for (n = 0; n < 10 && s !== v; n++) begin
         @(posedge ref_clk);
         #1;
      end
      `CHK(s, v)
   endtask : waitSig

   initial begin
      errors = 0;
      checksDone = 0;
      {chipDonePin, chipPassPin, portDonePin, portPassPin} = 4'h0;
      hardErrEvent = 16'h0;
      softErrEvent = 16'h0;
      failAddrIn = rnd();
      portParamIn = rnd();
      doReset();
      acc(1'h0, OFF_NODE_TYPE, 32'h0);
      acc(1'h1, OFF_NODE_TYPE, 32'hffff_ffff);
      acc(1'h0, OFF_NODE_TYPE, 32'h0);
      acc(1'h0, OFF_CTRL_STATUS, 32'h0);
      acc(1'h1, OFF_CTRL_STATUS, 32'hffff_e800);
      acc(1'h0, OFF_CTRL_STATUS, 32'h0);
      `CHK(busDriverEn, 1'h0)
      for (int k = 0; k < 4; k++) begin
         r = rnd();
         @(posedge ref_clk);
         #1;
         hardErrEvent = k[0] ? r[15:0] : 16'h0;
         softErrEvent = k[1] ? r[31:16] : 16'h0;
         mErr = mErr | {hardErrEvent, softErrEvent};
         @(posedge ref_clk);
         #1;
         hardErrEvent = 16'h0;
         softErrEvent = 16'h0;
         acc(1'h0, OFF_CTRL_STATUS, 32'h0);
         acc(1'h0, OFF_BUS_ERR, 32'h0);
         acc(1'h1, OFF_BUS_ERR, rnd());
         acc(1'h0, OFF_CTRL_STATUS, 32'h0);
         acc(1'h1, OFF_BUS_ERR, 32'hffff_ffff);
         acc(1'h0, OFF_CTRL_STATUS, 32'h0);
      end
      for (int i = 0; i < NUM_PLAIN; i++) begin
         acc(1'h1, PLAIN_OFF[i], rnd());
         acc(1'h0, PLAIN_OFF[i], 32'h0);
      end
      foreach (rsvd[i]) begin
         acc(1'h1, rsvd[i], rnd());
         acc(1'h0, rsvd[i], 32'h0);
      end
      // Port fails first; a later port pass must not count
      pins(4'h2);
      repeat (5) @(posedge ref_clk);
      pins(4'hf);
      mChip = 1'h1;
      waitSig(busDriverEn, 1'h1);
      mPass = 1'h1;
      repeat (5) @(posedge ref_clk);
      #1;
      `CHK(selftestFailed, 1'h1)
      acc(1'h0, OFF_CTRL_STATUS, 32'h0);
      acc(1'h1, OFF_CTRL_STATUS, 32'h0000_0800);
      acc(1'h1, OFF_CTRL_STATUS, 32'h0000_1800);
      `CHK(selftestFailed, 1'h0)
      // Second reset with both tests passing
      pins(4'h0);
      doReset();
      pins(4'hf);
      mChip = 1'h1;
      waitSig(busDriverEn, 1'h1);
      mPass = 1'h1;
      waitSig(selftestFailed, 1'h0);
      mFail = 1'h0;
      acc(1'h0, OFF_CTRL_STATUS, 32'h0);
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      $display("ERROR %0t: run did not finish", $time);
      stop_test();
   end
endmodule : backplane_node_required_regs_test

// *** verif/bnr_host_model.sv ***
module bnr_host_model
   import bnr_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Request lines
   output logic regReq,
   output logic regWrite,
   output logic [ADDR_W-1:0] regAddr,
   output logic [DATA_W-1:0] regWdata,
   // Answer lines
   input wire logic regAck,
   input wire logic regNoAck,
   input wire logic [DATA_W-1:0] regRdata
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      regReq = 1'h0;
      regWrite = 1'h0;
      regAddr = 8'h00;
      regWdata = 32'h0;
   end

   // One access; gap + 1 idle cycles first so slow requesters are covered.
   task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input int gap,
      output logic [DATA_W-1:0] rd, output logic ak, output logic nk,
      output logic tout);
      int n;
      repeat (gap + 1) @(posedge ref_clk);
      #1;
      regReq = 1'h1;
      regWrite = wr;
      regAddr = a;
      regWdata = d;
      @(posedge ref_clk);
      #1;
      // Released lines show the inverse so stale values never match
      regReq = 1'h0;
      regWrite = ~wr;
      regAddr = ~a;
      regWdata = ~d;
      n = 0;
      while (!(regAck === 1'h1 || regNoAck === 1'h1) && n < 4) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      tout = (n >= 4);
      rd = regRdata;
      ak = regAck;
      nk = regNoAck;
   endtask : access
endmodule : bnr_host_model
